// ---- rtl/host_serial_fifo.v ----
/*
 * Holds no logic: the receive FIFO module stands at the end of
 * host_serial_port.v, so that one design file carries the whole block.
 */

// ---- rtl/host_serial_map.vh ----
/*
 * Constants of the host serial port: frame layout, baud timing, reset
 * values of the line pins. Definitions only; included by bare name.
 */
`ifndef HOST_SERIAL_MAP_VH
`define HOST_SERIAL_MAP_VH

`define CLK_HZ          200000000
`define BAUD_HZ         115200
`define BAUD_DIV        (`CLK_HZ / `BAUD_HZ)
`define DATA_BITS       8
`define FIFO_DEPTH      32
`define LINE_IDLE       1'b1
`define LINE_START      1'b0
`define LINE_STOP       1'b1
`define FLOW_STOP_N     1'b1
`define FLOW_GO_N       1'b0

`endif

// ---- rtl/host_serial_port.v ----
/*
 * Host serial port: 8N1 transmitter and receiver with optional hardware
 * flow control; a 32-word FIFO buffers received characters.
 * The FIFO module follows the port module in this file.
 * Assumes all inputs synchronous to clk (200 MHz); flow enable is a pin.
 */
// How it works
// (RULE1) Characters go to the host serially on host_tx_line.
// (RULE2) Characters from the host are received from host_rx_line.
// (RULE3) Clear-to-send is heeded only while flow control is enabled.
// (RULE4) With flow control on, clear-to-send low lets a frame start.
// (RULE5) With flow control on, clear-to-send high blocks new frames.
// (RULE6) Clear-to-send is looked at only when a frame starts.
// (RULE7) Ready-to-send is driven as a flow signal only with flow on.
// (RULE8) Ready-to-send is low while the receiver can take data; the code raises it once the FIFO holds DEPTH - HEADROOM (28) words.
// (RULE9) Ready-to-send is high while the receiver cannot take data.
// (RULE10) In USB use the other party supplies a 4 MHz clock on the pin.
// (RULE11) With flow off, clear-to-send is ignored, ready held low.
`timescale 1ns/100ps
`include "host_serial_map.vh"
module host_serial_port #(
   parameter BAUD_DIV  = `BAUD_DIV,
   parameter DEPTH     = `FIFO_DEPTH,
   parameter AW        = 5,
   parameter HEADROOM  = 4
) (
   // Clock and reset
   input  wire       clk,
   input  wire       arst_n,
   // Configuration
   input  wire       flow_enable,
   // Host link
   output reg        host_tx_line,
   input  wire       host_rx_line,
   input  wire       host_clear_to_send_n,
   output reg        host_ready_to_send_n,
   // Transmit data from the device
   input  wire       tx_valid,
   output wire       tx_ready,
   input  wire [7:0] tx_data,
   // Receive data to the device
   output wire       rx_valid,
   input  wire       rx_ready,
   output wire [7:0] rx_data
);
   localparam [1:0] ST_IDLE  = 2'd0;
   localparam [1:0] ST_START = 2'd1;
   localparam [1:0] ST_DATA  = 2'd2;
   localparam [1:0] ST_STOP  = 2'd3;

   // Transmitter
   reg  [1:0]  tx_state;
   reg  [31:0] tx_cnt;
   reg  [2:0]  tx_bit;
   reg  [7:0]  tx_shift;
   wire        cts_ok;
   wire        tx_go;

   // Receiver
   reg  [1:0]  rx_state;
   reg  [31:0] rx_cnt;
   reg  [2:0]  rx_bit;
   reg  [7:0]  rx_shift;
   reg         rx_push;
   wire [AW:0] fifo_level;

   function baud_done;
      input [31:0] cnt;
      begin
         baud_done = (cnt == BAUD_DIV - 1);
      end
   endfunction

   assign cts_ok   = ~flow_enable | ~host_clear_to_send_n; // see RULE3
   assign tx_go    = (tx_state == ST_IDLE) & tx_valid & cts_ok; // see RULE6
   assign tx_ready = tx_go; // see RULE4 see RULE5 see RULE11

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_state     <= ST_IDLE;
         tx_cnt       <= 32'h0;
         tx_bit       <= 3'h0;
         tx_shift     <= 8'h00;
         host_tx_line <= `LINE_IDLE;
      end else begin
         case (tx_state)
            ST_IDLE: begin
               host_tx_line <= `LINE_IDLE;
               tx_cnt       <= 32'h0;
               if (tx_go) begin
                  tx_shift     <= tx_data;
                  tx_state     <= ST_START;
                  host_tx_line <= `LINE_START; // see RULE1
               end
            end
            ST_START: begin
               // Frame runs to its end whatever clear-to-send does
               if (baud_done(tx_cnt)) begin
                  tx_cnt       <= 32'h0;
                  tx_bit       <= 3'h0;
                  tx_state     <= ST_DATA;
                  host_tx_line <= tx_shift[0];
               end else
                  tx_cnt <= tx_cnt + 32'h1;
            end
            ST_DATA: begin
               if (baud_done(tx_cnt)) begin
                  tx_cnt <= 32'h0;
                  if (tx_bit == `DATA_BITS - 1) begin
                     tx_state     <= ST_STOP;
                     host_tx_line <= `LINE_STOP;
                  end else begin
                     tx_bit       <= tx_bit + 3'h1;
                     tx_shift     <= {1'b0, tx_shift[7:1]};
                     host_tx_line <= tx_shift[1];
                  end
               end else
                  tx_cnt <= tx_cnt + 32'h1;
            end
            ST_STOP: begin
               if (baud_done(tx_cnt))
                  tx_state <= ST_IDLE; // see RULE6
               else
                  tx_cnt <= tx_cnt + 32'h1;
            end
            default: tx_state <= ST_IDLE;
         endcase
      end
   end

   // Receiver: sample mid-bit, drop frames with a bad stop bit
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_state <= ST_IDLE;
         rx_cnt   <= 32'h0;
         rx_bit   <= 3'h0;
         rx_shift <= 8'h00;
         rx_push  <= 1'b0;
      end else begin
         rx_push <= 1'b0;
         case (rx_state)
            ST_IDLE: begin
               rx_cnt <= 32'h0;
               if (host_rx_line == `LINE_START)
                  rx_state <= ST_START; // see RULE2
            end
            ST_START: begin
               if (rx_cnt == BAUD_DIV / 2 - 1) begin
                  rx_cnt <= 32'h0;
                  rx_bit <= 3'h0;
                  if (host_rx_line == `LINE_START)
                     rx_state <= ST_DATA;
                  else
                     rx_state <= ST_IDLE;
               end else
                  rx_cnt <= rx_cnt + 32'h1;
            end
            ST_DATA: begin
               if (baud_done(rx_cnt)) begin
                  rx_cnt   <= 32'h0;
                  rx_shift <= {host_rx_line, rx_shift[7:1]};
                  if (rx_bit == `DATA_BITS - 1)
                     rx_state <= ST_STOP;
                  else
                     rx_bit <= rx_bit + 3'h1;
               end else
                  rx_cnt <= rx_cnt + 32'h1;
            end
            ST_STOP: begin
               if (baud_done(rx_cnt)) begin
                  rx_state <= ST_IDLE;
                  rx_push  <= (host_rx_line == `LINE_STOP);
               end else
                  rx_cnt <= rx_cnt + 32'h1;
            end
            default: rx_state <= ST_IDLE;
         endcase
      end
   end

   // Ready-to-send: with flow on, raised while little room is left in the FIFO; held low with flow off
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         host_ready_to_send_n <= `FLOW_STOP_N;
      else if (!flow_enable)
         host_ready_to_send_n <= `FLOW_GO_N; // see RULE7 see RULE11
      else if (fifo_level >= DEPTH - HEADROOM)
         host_ready_to_send_n <= `FLOW_STOP_N; // see RULE9
      else
         host_ready_to_send_n <= `FLOW_GO_N; // see RULE8
   end

   host_serial_fifo #(
      .WIDTH (`DATA_BITS),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) rx_fifo (
      .clk       (clk),
      .arst_n    (arst_n),
      .in_valid  (rx_push),
      .in_ready  (),
      .in_data   (rx_shift),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (rx_data),
      .level     (fifo_level)
   );
endmodule

// Receive FIFO: flop storage, valid/ready on both sides
module host_serial_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   // Clock and reset
   input  wire             clk,
   input  wire             arst_n,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output reg  [WIDTH-1:0] out_data,
   // Level
   output reg  [AW:0]      level
);
   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0]    wr_ptr;
   reg  [AW-1:0]    rd_ptr;
   wire             push;
   wire             pop;

   function [AW-1:0] bump;
      input [AW-1:0] p;
      begin
         if (p == DEPTH - 1)
            bump = {AW{1'b0}};
         else
            bump = p + 1'b1;
      end
   endfunction

   assign in_ready  = (level != DEPTH);
   assign out_valid = (level != {(AW+1){1'b0}});
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @* begin
      out_data = mem[rd_ptr];
   end

   always @(posedge clk) begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         level  <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wr_ptr <= bump(wr_ptr);
         if (pop)
            rd_ptr <= bump(rd_ptr);
         if (push & ~pop)
            level <= level + 1'b1;
         else if (pop & ~push)
            level <= level - 1'b1;
      end
   end
endmodule

// ---- tb/host_serial_host_model.sv ----
/* Host end of the serial link: sends and decodes 8N1 characters.
   Assumes BAUD_DIV clocks a bit, as set on the port. */
`timescale 1ns/100ps
module host_serial_host_model #(parameter BAUD_DIV = 16) (
   input  wire clk,
   input  wire host_tx_line,
   input  wire host_ready_to_send_n,
   input  wire honour_rts,
   output reg  host_rx_line
);
   logic [7:0] got [$];
   logic [7:0] sh;
   logic       stall = 1'b0;
   initial host_rx_line = 1'b1;
   // Decode frames, LSB first
   always begin
      @(negedge host_tx_line);
      repeat (BAUD_DIV / 2) @(posedge clk);
      repeat (8) begin
         repeat (BAUD_DIV) @(posedge clk);
         sh = {host_tx_line, sh[7:1]};
      end
      repeat (BAUD_DIV) @(posedge clk);
      if (host_tx_line) got.push_back(sh);
   end
   task automatic send(input logic [7:0] b);
      int n;
      n = 0;
      while (honour_rts && host_ready_to_send_n && n < 9999) begin
         @(posedge clk);
         n++;
      end
      if (honour_rts && host_ready_to_send_n) stall = 1'b1;
      #1 host_rx_line = 1'b0;
      repeat (BAUD_DIV) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         #1 host_rx_line = b[i];
         repeat (BAUD_DIV) @(posedge clk);
      end
      #1 host_rx_line = 1'b1;
      repeat (BAUD_DIV) @(posedge clk);
   endtask
endmodule

// ---- tb/host_serial_port_checker.sv ----
/* Checker for the host serial port, bound to the port's own pins.
   Assumes one clock and an asynchronous active-low reset. */
`timescale 1ns/100ps
module host_serial_port_checker #(parameter BAUD_DIV = 16) (
   // Clock, reset, config
   input wire       clk,
   input wire       arst_n,
   input wire       flow_enable,
   // Host link
   input wire       host_tx_line,
   input wire       host_rx_line,
   input wire       host_clear_to_send_n,
   input wire       host_ready_to_send_n,
   // Device side
   input wire       tx_valid,
   input wire       tx_ready,
   input wire       rx_valid,
   input wire       rx_ready,
   input wire [7:0] tx_data,
   input wire [7:0] rx_data
);
   localparam int STOP = 9 * BAUD_DIV + 5;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire take = tx_valid && tx_ready;
   property p_start; take |=> !host_tx_line [*8]; endproperty
   a_start: assert property (p_start) else $error("no start bit");
   property p_stop; take |-> ##STOP host_tx_line; endproperty
   a_stop: assert property (p_stop) else $error("no stop bit");
   property p_go; take |-> !flow_enable || !host_clear_to_send_n; endproperty
   a_go: assert property (p_go) else $error("cts not heeded");
   property p_block;
      flow_enable && host_clear_to_send_n |-> !tx_ready;
   endproperty
   a_block: assert property (p_block) else $error("start under cts");
   property p_busy; take |=> !tx_ready [*8]; endproperty
   a_busy: assert property (p_busy) else $error("frame cut");
   property p_off; !flow_enable ##1 !flow_enable |-> !host_ready_to_send_n;
   endproperty
   a_off: assert property (p_off) else $error("rts with flow off");
   property p_take;
      flow_enable && !rx_valid ##1 flow_enable && !rx_valid
         |-> !host_ready_to_send_n;
   endproperty
   a_take: assert property (p_take) else $error("rts when empty");
   property p_rx; $rose(rx_valid) |-> $past(host_rx_line, 2); endproperty
   a_rx: assert property (p_rx) else $error("char without stop");
   c_take: cover property (flow_enable && take);
   c_full: cover property (flow_enable && host_ready_to_send_n);
   c_pop: cover property (rx_valid && rx_ready);
endmodule
bind host_serial_port host_serial_port_checker #(.BAUD_DIV(BAUD_DIV)) chk (
   .clk(clk), .arst_n(arst_n), .flow_enable(flow_enable),
   .host_tx_line(host_tx_line), .host_rx_line(host_rx_line),
   .host_clear_to_send_n(host_clear_to_send_n),
   .host_ready_to_send_n(host_ready_to_send_n), .tx_valid(tx_valid),
   .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_ready(rx_ready),
   .tx_data(tx_data), .rx_data(rx_data));

// ---- tb/host_serial_port_test.sv ----
/* Bench for the host serial port with a host model on its pins.
   Assumes a bit time cut to 16 clocks to keep the run short. */
`timescale 1ns/100ps
module host_serial_port_test;
   localparam D = 16;
   localparam USB_HALF = 25; // Half of a 4 MHz period at 200 MHz
   logic       clk = 1'b0, arst_n = 1'b0, flow_enable = 1'b0, cts_n = 1'b1;
   logic       tx_valid = 1'b0, rx_ready = 1'b0, honour = 1'b0;
   logic [7:0] tx_data = 8'h00;
   wire        tx_line, rx_line, rts_n, tx_ready, rx_valid;
   wire  [7:0] rx_data;
   int         fails = 0, total_checks = 0;
   always #2.5 clk = ~clk;
   host_serial_port #(.BAUD_DIV(D)) uut (.clk(clk), .arst_n(arst_n),
      .flow_enable(flow_enable), .host_tx_line(tx_line),
      .host_rx_line(rx_line), .host_clear_to_send_n(cts_n),
      .host_ready_to_send_n(rts_n), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_data(rx_data));
   host_serial_host_model #(.BAUD_DIV(D)) host (.clk(clk),
      .host_tx_line(tx_line), .host_ready_to_send_n(rts_n),
      .honour_rts(honour), .host_rx_line(rx_line));
   task automatic stop_test;
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] e, g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic put(input logic [7:0] b);
      int n;
      n = 0;
      tx_data = b;
      tx_valid = 1'b1;
      do begin @(negedge clk); n++; end while (!tx_ready && n < 5000);
      if (!tx_ready) begin fails++; stop_test; end
      tick(1);
      tx_valid = 1'b0;
   endtask
   task automatic wait_got(input int k);
      int n;
      n = 0;
      while (host.got.size() < k && n < 2000) begin tick(1); n++; end
      chk("host char count", k, host.got.size());
      if (host.got.size() < k) stop_test;
   endtask
   task automatic send_run(input int first, last);
      for (int i = first; i <= last; i++) host.send(8'h40 + i[7:0]);
      if (host.stall) begin fails++; stop_test; end
   endtask
   task automatic pop_run(input int first, last);
      rx_ready = 1'b1;
      for (int i = first; i <= last; i++) begin
         @(negedge clk);
         chk("rx char", 8'h40 + i[7:0], rx_data);
         @(posedge clk);
      end
      #1 rx_ready = 1'b0;
   endtask
   task automatic t_flow_off;
      put(8'ha5);
      // Pin runs as the USB device clock while flow is off
      repeat (8) begin
         tick(USB_HALF);
         cts_n = ~cts_n;
      end
      wait_got(1);
      chk("tx char", 8'ha5, host.got.pop_front());
      chk("rts flow off", 8'h00, {7'h0, rts_n});
   endtask
   task automatic t_cts;
      flow_enable = 1'b1;
      cts_n = 1'b0;
      put(8'h96);
      tick(40);
      cts_n = 1'b1;
      tx_data = 8'h3c;
      tx_valid = 1'b1;
      tick(12 * D);
      chk("held char", 8'h00, {7'h0, tx_ready});
      wait_got(1);
      chk("frame under cts", 8'h96, host.got.pop_front());
      cts_n = 1'b0;
      put(8'h3c);
      wait_got(1);
      chk("tx after cts", 8'h3c, host.got.pop_front());
   endtask
   task automatic t_fill;
      honour = 1'b1;
      send_run(0, 27);
      chk("rts near full", 8'h01, {7'h0, rts_n});
      tick(1);
      pop_run(0, 3);
      tick(2);
      chk("rts reopened", 8'h00, {7'h0, rts_n});
      send_run(28, 31);
      chk("rts refilled", 8'h01, {7'h0, rts_n});
      tick(1);
      pop_run(4, 31);
      @(negedge clk);
      chk("rx empty", 8'h00, {7'h0, rx_valid});
      tick(2);
      chk("rts drained", 8'h00, {7'h0, rts_n});
   endtask
   initial begin
      tick(8);
      arst_n = 1'b1;
      tick(2);
      t_flow_off;
      t_cts;
      t_fill;
      stop_test;
   end
endmodule
